// ==== rtl/wpd_top.sv ====
// Purpose: Watchdog timer with halt, idle, sleep and wake-up control,
//          reached over APB.
// Assumes: sub_clock, port A and the option strap are asynchronous
//          pins; CPU strobes are one-cycle pulses on pclk.
// Notes:   Registers sit in the low byte of each word.
//
// Operation
// - Halt, idle on, sysclk-on-in-idle off: stop system clock and CPU.
// - Halt, idle on, sysclk-on-in-idle on: stop CPU, clocks keep running.
// - Idle entry keeps state, clears watchdog counter, counting resumes.
// - Power-down entry sets power-down flag, clears time-out flag.
// - Wake on enabled port A fall, interrupt or watchdog overflow.
// - Overflow while halted sets time-out, resets only PC and SP.
// - Power-down flag: cleared by power-up or clear, set by halt.
// - Per-pin wake enables; port wake resumes after the halt.
// - Disabled or stack-full interrupt wake resumes; request stays.
// - Enabled interrupt with stack room takes normal response.
// - Request already set before halt cannot wake.
// - Period field picks 2^8..2^18 source cycles.
// - Always-on option: both valid codes run; others reset.
// - Register option: 10101B off, 01010B on; others reset.
// - Invalid code resets after 2 to 3 sub clock cycles.
// - Invalid-code reset sets control reset flag; software clears.
// - Power-on loads code 01010B and period 011.
// - Running overflow resets device and sets time-out flag.
// - Counter cleared by invalid-code reset, clear or halt.
// - Sleep, nothing on: stop both clocks, stop and clear watchdog.
// - Sleep, watchdog or detector on: sub clock runs, counter resumes.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wpd_cfg.svh"

module wpd_top
  import wpd_pkg::*;
#(
  parameter int CNT_W = 18,
  parameter int NINT  = 4
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output var  logic [31:0]     prdata,
  output var  logic            pready,
  output var  logic            pslverr,
  input  wire logic            halt_exec,
  input  wire logic            watchdog_clear_instruction_exec,
  input  wire logic            always_en_opt,
  input  wire logic            lvd_on,
  input  wire logic            sub_clock,
  input  wire logic [7:0]      porta_pin,
  input  wire logic [NINT-1:0] int_req,
  input  wire logic [NINT-1:0] int_enable,
  input  wire logic            stack_full,
  output var  logic            sysclk_run,
  output var  logic            subclk_run,
  output var  logic            cpu_run,
  output var  logic            dev_reset,
  output var  logic            pc_sp_reset,
  output var  logic            resume_next,
  output var  logic            int_response
);

  generate
    if (CNT_W < `WPD_CNT_MIN || CNT_W > 31) begin : g_bad_w
      $error("CNT_W must lie between 18 and 31");
    end
    if (NINT < 1) begin : g_bad_n
      $error("NINT must be at least 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [9:0] pins_s;
  logic       sub_prev_q;
  logic [7:0] pa_prev_q;

  wpd_sync #(.W(10)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({always_en_opt, sub_clock, porta_pin}),
    .sync_out (pins_s)
  );

  wire       always_s = pins_s[9];
  wire       sub_s    = pins_s[8];
  wire [7:0] pa_s     = pins_s[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_prev_q <= 1'b0;
      pa_prev_q  <= 8'h00;
    end else begin
      sub_prev_q <= sub_s;
      pa_prev_q  <= pa_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  wpd_watchdog_control_s       watchdog_control_q;
  logic            syson_q;
  logic            wrf_q;
  logic            idle_enable_q;
  logic [7:0]      wake_en_q;
  logic            pdf_q;
  logic            tof_q;
  wpd_mode_e       mode_q;
  wpd_mode_e       mode_d;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0]      bad_q;
  logic [NINT-1:0] int_old_q;

  ////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state, so pready always comes from a flop

  wire acc    = psel & penable & pready;
  wire sample = psel & penable & ~pready;
  wire sel_wd = paddr == `WPD_OFS_WATCHDOG_CONTROL;
  wire sel_ct = paddr == `WPD_OFS_CTRL;
  wire sel_wk = paddr == `WPD_OFS_WAKE;
  wire sel_st = paddr == `WPD_OFS_STAT;
  wire sel_md = paddr == `WPD_OFS_MODE;
  wire hit    = sel_wd | sel_ct | sel_wk | sel_st | sel_md;
  wire wr_wd  = acc & pwrite & sel_wd;
  wire wr_ct  = acc & pwrite & sel_ct;
  wire wr_wk  = acc & pwrite & sel_wk;
  wire wr_md  = acc & pwrite & sel_md;

  wire [7:0] ctrl_rd = {syson_q, 6'h00, wrf_q};
  wire [7:0] mode_rd = {6'h00, idle_enable_q, 1'b0};

  wpd_stat_s stat;
  wire [7:0] stat_rd = {2'h0, stat};

  wire [7:0] rd_byte = sel_wd ? watchdog_control_q :
                       sel_ct ? ctrl_rd :
                       sel_wk ? wake_en_q :
                       sel_st ? stat_rd :
                       sel_md ? mode_rd : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= sample;
      pslverr <= sample & ~hit;
      if (sample) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog enable, period and counter

  wire code_on  = watchdog_control_q.code == `WPD_CODE_ON;
  wire code_off = watchdog_control_q.code == `WPD_CODE_OFF;
  wire code_ok  = code_on | code_off;
  // Always-on option treats both valid codes as run
  wire wdt_en   = code_on | (code_off & always_s);
  wire halted   = mode_q != MD_RUN;

  // Sub clock is stopped in full sleep, so nothing ticks there
  wire sub_tick = sub_s & ~sub_prev_q & (mode_q != MD_SLEEP_ALL);

  function automatic logic [4:0] period_shift(input logic [2:0] sel);
    unique case (sel)
      3'h0: period_shift = `WPD_SH0;
      3'h1: period_shift = `WPD_SH1;
      3'h2: period_shift = `WPD_SH2;
      3'h3: period_shift = `WPD_SH3;
      3'h4: period_shift = `WPD_SH4;
      3'h5: period_shift = `WPD_SH5;
      3'h6: period_shift = `WPD_SH6;
      3'h7: period_shift = `WPD_SH7;
    endcase
  endfunction : period_shift

  wire [4:0]       shift = period_shift(watchdog_control_q.period);
  wire [CNT_W-1:0] lim   = ~({CNT_W{1'b1}} << shift);

  // Single-cycle event: a tick is one pclk wide, counter clears at once
  wire wdt_ovf  = wdt_en & sub_tick & (cnt_q == lim);

  // Third sub edge seen while invalid resets: 2 to 3 sub periods
  wire bad_fire = ~code_ok & sub_tick &
                  (bad_q == `WPD_BAD_TICKS - 2'h1);

  wire halt_take = halt_exec & ~halted;
  wire run_rst   = bad_fire | (wdt_ovf & ~halted);
  wire halt_ovf  = wdt_ovf & halted;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_q <= 2'h0;
    end else if (code_ok || bad_fire) begin
      bad_q <= 2'h0;
    end else if (sub_tick) begin
      bad_q <= bad_q + 2'h1;
    end
  end

  wire cnt_clr = halt_take | watchdog_clear_instruction_exec | bad_fire
               | wdt_ovf | ~wdt_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (cnt_clr) begin
      cnt_q <= '0;
    end else if (sub_tick) begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake sources

  wire [7:0] pa_fall = pa_prev_q & ~pa_s & wake_en_q;
  wire       pa_wake = |pa_fall;

  // Requests already pending at halt are masked from waking
  wire [NINT-1:0] int_new = int_req & ~int_old_q;
  wire int_wake = |int_new;
  wire int_svc  = |(int_new & int_enable) & ~stack_full;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_old_q <= '0;
    end else if (halt_take) begin
      int_old_q <= int_req;
    end else if (!halted) begin
      int_old_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode sequencing

  wire sub_needed = wdt_en | lvd_on;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      MD_RUN: begin
        if (halt_exec) begin
          if (idle_enable_q && syson_q) begin
            mode_d = MD_IDLE_RUN;
          end else if (idle_enable_q) begin
            mode_d = MD_IDLE_STOP;
          end else if (sub_needed) begin
            mode_d = MD_SLEEP_SUB;
          end else begin
            mode_d = MD_SLEEP_ALL;
          end
        end
      end
      MD_IDLE_STOP, MD_IDLE_RUN,
      MD_SLEEP_ALL, MD_SLEEP_SUB: begin
        if (wdt_ovf || int_wake || pa_wake) begin
          mode_d = MD_RUN;
        end
      end
      default: mode_d = MD_RUN;
    endcase
    if (run_rst) begin
      mode_d = MD_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MD_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers; a device reset reloads all of them but wrf_q

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_control_q    <= `WPD_WATCHDOG_CONTROL_POR;
      syson_q   <= 1'b0;
      idle_enable_q   <= 1'b1;
      wake_en_q <= `WPD_WAKE_POR;
    end else if (run_rst) begin
      watchdog_control_q    <= `WPD_WATCHDOG_CONTROL_POR;
      syson_q   <= 1'b0;
      idle_enable_q   <= 1'b1;
      wake_en_q <= `WPD_WAKE_POR;
    end else begin
      if (wr_wd) begin
        watchdog_control_q <= pwdata[7:0];
      end
      if (wr_ct) begin
        syson_q <= pwdata[`WPD_CTRL_SYSON];
      end
      if (wr_md) begin
        idle_enable_q <= pwdata[`WPD_MODE_IDLE_ENABLE];
      end
      if (wr_wk) begin
        wake_en_q <= pwdata[7:0];
      end
    end
  end

  // Set wins over a clearing write in the same cycle
  wire wrf_clr = wr_ct & ~pwdata[`WPD_CTRL_WRF];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrf_q <= 1'b0;
    end else if (bad_fire) begin
      wrf_q <= 1'b1;
    end else if (wrf_clr) begin
      wrf_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdf_q <= 1'b0;
      tof_q <= 1'b0;
    end else begin
      if (halt_take) begin
        pdf_q <= 1'b1;
      end else if (watchdog_clear_instruction_exec) begin
        pdf_q <= 1'b0;
      end
      if (wdt_ovf) begin
        tof_q <= 1'b1;
      end else if (halt_take) begin
        tof_q <= 1'b0;
      end
    end
  end

  assign stat = '{wdt_on: wdt_en, mode: mode_q,
                  powerdown_flag: pdf_q, tof: tof_q};

  ////////////////////////////////////////////////////////////////////////
  // Outputs to clock, reset and CPU control

  // Overflow has priority over other wake sources in the same cycle
  wire wake_any = halted & ~wdt_ovf & ~bad_fire;
  wire wk_int   = wake_any & int_wake;
  wire wk_res   = wake_any & ((int_wake & ~int_svc)
                  | (~int_wake & pa_wake));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysclk_run   <= 1'b1;
      subclk_run   <= 1'b1;
      cpu_run      <= 1'b1;
      dev_reset    <= 1'b0;
      pc_sp_reset  <= 1'b0;
      resume_next  <= 1'b0;
      int_response <= 1'b0;
    end else begin
      sysclk_run   <= (mode_d == MD_RUN) |
                      (mode_d == MD_IDLE_RUN);
      subclk_run   <= mode_d != MD_SLEEP_ALL;
      cpu_run      <= mode_d == MD_RUN;
      dev_reset    <= run_rst;
      pc_sp_reset  <= halt_ovf;
      resume_next  <= wk_res;
      int_response <= wk_int & int_svc;
    end
  end

endmodule : wpd_top

`default_nettype wire

// ==== rtl/wpd_cfg.svh ====
// Purpose: Offsets, field positions, reset values and counts of the
//          watchdog and power-down block.
// Assumes: 8-bit registers, each in the low byte of one APB word.
// Notes:   Definitions only.
`ifndef WPD_CFG_SVH
`define WPD_CFG_SVH

`define WPD_OFS_WATCHDOG_CONTROL   8'h00
`define WPD_OFS_CTRL   8'h04
`define WPD_OFS_WAKE   8'h08
`define WPD_OFS_STAT   8'h0C
`define WPD_OFS_MODE   8'h10

`define WPD_WATCHDOG_CONTROL_POR   8'h53
`define WPD_CODE_ON    5'h0A
`define WPD_CODE_OFF   5'h15
`define WPD_WAKE_POR   8'h00

`define WPD_CTRL_SYSON 7
`define WPD_CTRL_WRF   0
`define WPD_MODE_IDLE_ENABLE 1

`define WPD_BAD_TICKS  2'h3
`define WPD_CNT_MIN    18

`define WPD_SH0        5'h08
`define WPD_SH1        5'h0A
`define WPD_SH2        5'h0C
`define WPD_SH3        5'h0E
`define WPD_SH4        5'h0F
`define WPD_SH5        5'h10
`define WPD_SH6        5'h11
`define WPD_SH7        5'h12

`endif

// ==== rtl/wpd_pkg.sv ====
// Purpose: Types shared by the watchdog and power-down block.
// Assumes: Constants live in wpd_cfg.svh.
// Notes:   Mode codes are binary and fixed.
package wpd_pkg;

  typedef enum logic [2:0] {
    MD_RUN        = 3'b000,
    MD_IDLE_STOP  = 3'b001,
    MD_IDLE_RUN   = 3'b010,
    MD_SLEEP_ALL  = 3'b011,
    MD_SLEEP_SUB  = 3'b100
  } wpd_mode_e;

  typedef struct packed {
    logic [4:0] code;
    logic [2:0] period;
  } wpd_watchdog_control_s;

  typedef struct packed {
    logic      wdt_on;
    wpd_mode_e mode;
    logic      powerdown_flag;
    logic      tof;
  } wpd_stat_s;

endpackage : wpd_pkg

// ==== rtl/wpd_sync.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous levels.
// Assumes: Inputs change slowly against pclk.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ps
`default_nettype none

module wpd_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : wpd_sync

`default_nettype wire

// ==== sim/wpd_checker.sv ====
// Purpose: Port-level checks of the watchdog and power-down block.
// Assumes: Single pclk domain, presetn asynchronous active low.
// Notes:   Bound into wpd_top after the module.
`timescale 1ns/1ps
`default_nettype none

module wpd_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic halt_exec,
  input wire logic stack_full,
  input wire logic sysclk_run,
  input wire logic subclk_run,
  input wire logic cpu_run,
  input wire logic dev_reset,
  input wire logic pc_sp_reset,
  input wire logic resume_next,
  input wire logic int_response
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  // Wake pulse lands in the first cycle the CPU runs again
  sequence s_wake;
    cpu_run && !$past(cpu_run);
  endsequence
  ////////////////////////////////////////////////////////////////////
  AST_APB_WAIT:
    assert property (s_setup |=> s_answer)
    else $error("pready not two cycles after setup");
  AST_ERR_READY:
    assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_HALT_STOP:
    assert property (halt_exec && cpu_run |-> ##[1:2] !cpu_run)
    else $error("cpu still runs after halt");
  AST_CLK_CPU:
    assert property (!sysclk_run |-> !cpu_run)
    else $error("cpu runs without system clock");
  AST_SUB_STOP:
    assert property (!subclk_run |-> !sysclk_run)
    else $error("system clock runs with sub clock stopped");
  AST_ONE_RESET:
    assert property (dev_reset |=> !dev_reset)
    else $error("device reset longer than one cycle");
  AST_ONE_PCSP:
    assert property (pc_sp_reset |-> !dev_reset ##1 !pc_sp_reset)
    else $error("pc sp reset not a lone pulse");
  AST_PCSP_WAKE:
    assert property (pc_sp_reset |-> s_wake)
    else $error("pc sp reset without wake");
  AST_RESUME_WAKE:
    assert property (resume_next |-> s_wake)
    else $error("resume without wake");
  AST_INT_RESP:
    assert property (int_response |-> !$past(stack_full) && cpu_run)
    else $error("interrupt response with full stack");
  AST_WAKE_CAUSE:
    assert property ($rose(cpu_run) |->
      pc_sp_reset || resume_next || int_response || dev_reset)
    else $error("cpu woke without a wake event");
endmodule : wpd_checker

bind wpd_top wpd_checker i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
  .stack_full(stack_full), .sysclk_run(sysclk_run),
  .subclk_run(subclk_run), .cpu_run(cpu_run), .dev_reset(dev_reset),
  .pc_sp_reset(pc_sp_reset), .resume_next(resume_next),
  .int_response(int_response)
);

`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Register-level bench of the watchdog and power-down block.
// Assumes: Sub clock made at one eighth of pclk, period code 0 for speed.
// Notes:   Pulses sampled at the falling edge; APB answers at rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "wpd_cfg.svh"

module tb;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, halt_exec = 1'h0, watchdog_clear_instruction_exec = 1'h0;
  logic        always_en_opt = 1'h0, lvd_on = 1'h0, sub_clock = 1'h0;
  logic        stack_full = 1'h0;
  logic [7:0]  paddr = 8'h00, porta_pin = 8'hFF;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [3:0]  int_req = 4'h0, int_enable = 4'h0;
  logic [2:0]  sdiv = 3'h0;
  logic        rerr;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, sysclk_run, subclk_run, cpu_run;
  wire logic   dev_reset, pc_sp_reset, resume_next, int_response;
  wire logic [3:0] ev = {int_response, resume_next, pc_sp_reset, dev_reset};
  int          n_errors = 0, cmp_count = 0, cyc = 0, sub_ticks = 0, t0, i;
  logic [7:0]  h_mode [5] = '{8'h00, 8'h02, 8'h02, 8'h00, 8'h00};
  logic [7:0]  h_ctrl [5] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
  logic [7:0]  h_watchdog_control [5] = '{8'hA8, 8'h50, 8'h50, 8'hA8, 8'h50};
  logic [7:0]  h_stat [5] = '{8'h12, 8'h26, 8'h2A, 8'h0E, 8'h32};
  logic [1:0]  h_run  [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h1};
  logic [3:0]  h_pre  [3] = '{4'h1, 4'h0, 4'h0};
  logic [3:0]  h_req  [3] = '{4'h3, 4'h4, 4'h2};
  logic        h_stk  [3] = '{1'h0, 1'h0, 1'h1};
  int          h_ev   [3] = '{3, 2, 2};

  wpd_top #(.CNT_W(18), .NINT(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
    .watchdog_clear_instruction_exec(watchdog_clear_instruction_exec), .always_en_opt(always_en_opt),
    .lvd_on(lvd_on), .sub_clock(sub_clock), .porta_pin(porta_pin),
    .int_req(int_req), .int_enable(int_enable), .stack_full(stack_full),
    .sysclk_run(sysclk_run), .subclk_run(subclk_run), .cpu_run(cpu_run),
    .dev_reset(dev_reset), .pc_sp_reset(pc_sp_reset),
    .resume_next(resume_next), .int_response(int_response)
  );
  ////////////////////////////////////////////////////////////////////
  initial forever #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    sdiv <= sdiv + 3'h1;
    sub_clock <= sdiv[2];
    if (sdiv == 3'h3) sub_ticks <= sub_ticks + 1;
  end

  // Bench hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  task finish_test();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Values read here are those the design sampled at this edge
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(nm, rdat, exp);
  endtask : rd

  // One-cycle halt (h=1) or watchdog clear (h=0) strobe
  task strobe(input logic h);
    @(posedge pclk);
    halt_exec <= h;
    watchdog_clear_instruction_exec <= ~h;
    @(posedge pclk);
    halt_exec <= 1'h0;
    watchdog_clear_instruction_exec <= 1'h0;
  endtask : strobe

  task wait_ev(input string nm, input int k, input int lim);
    int n;
    n = 0;
    while (ev[k] !== 1'h1 && n < lim) begin
      @(negedge pclk);
      n++;
    end
    check(nm, ev[k], 1'h1);
    @(posedge pclk);
  endtask : wait_ev
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd("watchdog_control", `WPD_OFS_WATCHDOG_CONTROL, 32'h53);
    rd("ctrl", `WPD_OFS_CTRL, 32'h0);
    rd("wake", `WPD_OFS_WAKE, 32'h0);
    rd("stat", `WPD_OFS_STAT, 32'h20);
    rd("mode", `WPD_OFS_MODE, 32'h2);
    rd("hole", 8'h14, 32'h0);
    check("slverr", rerr, 1'h1);
    wr(`WPD_OFS_STAT, 32'hFF);
    rd("stat_ro", `WPD_OFS_STAT, 32'h20);
    // Second clear must restart the count
    wr(`WPD_OFS_WATCHDOG_CONTROL, 32'h50);
    strobe(1'h0);
    repeat (800) @(posedge pclk);
    strobe(1'h0);
    t0 = sub_ticks;
    wait_ev("ovf_reset", 0, 2400);
    t0 = sub_ticks - t0;
    check("ovf_ticks", t0 inside {[255:257]}, 1'h1);
    rd("stat_tof", `WPD_OFS_STAT, 32'h21);
    rd("watchdog_control_reload", `WPD_OFS_WATCHDOG_CONTROL, 32'h53);
    wr(`WPD_OFS_WAKE, 32'h1);
    for (i = 0; i < 5; i++) begin
      // First pass: watchdog off, detector alone keeps the sub clock
      lvd_on <= (i == 0);
      wr(`WPD_OFS_MODE, {24'h0, h_mode[i]});
      wr(`WPD_OFS_CTRL, {24'h0, h_ctrl[i]});
      wr(`WPD_OFS_WATCHDOG_CONTROL, {24'h0, h_watchdog_control[i]});
      strobe(1'h0);
      strobe(1'h1);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check("clocks", {sysclk_run, subclk_run}, h_run[i]);
      rd("stat_halt", `WPD_OFS_STAT, {24'h0, h_stat[i]});
      porta_pin <= 8'hFD;
      repeat (8) @(posedge pclk);
      @(negedge pclk);
      check("masked_pin", cpu_run, 1'h0);
      @(posedge pclk);
      porta_pin <= 8'hFC;
      wait_ev("pin_wake", 2, 20);
      porta_pin <= 8'hFF;
      repeat (4) @(posedge pclk);
    end
    strobe(1'h0);
    rd("pdf_clr", `WPD_OFS_STAT, 32'h20);
    // Clear well before the halt, so only the halt restarts the count
    repeat (800) @(posedge pclk);
    strobe(1'h1);
    t0 = sub_ticks;
    wait_ev("halt_ovf", 1, 2400);
    t0 = sub_ticks - t0;
    check("halt_ticks", t0 inside {[255:257]}, 1'h1);
    rd("stat_wake", `WPD_OFS_STAT, 32'h23);
    rd("watchdog_control_kept", `WPD_OFS_WATCHDOG_CONTROL, 32'h50);
    wr(`WPD_OFS_WATCHDOG_CONTROL, 32'hA8);
    wr(`WPD_OFS_MODE, 32'h2);
    int_enable <= 4'h3;
    for (i = 0; i < 3; i++) begin
      int_req <= h_pre[i];
      stack_full <= h_stk[i];
      strobe(1'h1);
      repeat (8) @(posedge pclk);
      @(negedge pclk);
      check("early_wake", cpu_run, 1'h0);
      @(posedge pclk);
      int_req <= h_req[i];
      wait_ev("int_wake", h_ev[i], 20);
      int_req <= 4'h0;
    end
    stack_full <= 1'h0;
    wr(`WPD_OFS_WATCHDOG_CONTROL, 32'h00);
    t0 = sub_ticks;
    wait_ev("bad_reset", 0, 60);
    check("bad_ticks", (sub_ticks - t0) inside {[2:3]}, 1'h1);
    rd("wrf_set", `WPD_OFS_CTRL, 32'h1);
    rd("watchdog_control_por", `WPD_OFS_WATCHDOG_CONTROL, 32'h53);
    wr(`WPD_OFS_CTRL, 32'h1);
    rd("wrf_keep", `WPD_OFS_CTRL, 32'h1);
    wr(`WPD_OFS_CTRL, 32'h0);
    rd("wrf_clr", `WPD_OFS_CTRL, 32'h0);
    wr(`WPD_OFS_WATCHDOG_CONTROL, 32'hA8);
    apb(1'h0, `WPD_OFS_STAT, 32'h0);
    check("wdt_off", rdat & 32'h3C, 32'h0);
    always_en_opt <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h0, `WPD_OFS_STAT, 32'h0);
    check("wdt_always", rdat & 32'h3C, 32'h20);
    wr(`WPD_OFS_WATCHDOG_CONTROL, 32'hF8);
    wait_ev("bad_always", 0, 60);
    finish_test();
  end
endmodule : tb

`default_nettype wire
